// ===== ltw_pkg.sv
// Constants for the timebase, watchdog and capture block.
// Assumes a single 125 MHz clock that also serves as the oscillator.
package ltw_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] LTW_IDX_CTRL = 8'h0B;
  localparam logic [7:0] LTW_IDX_CAPT = 8'h0C;
  localparam logic [7:0] LTW_ADDR_CTRL = 8'h2C;
  localparam logic [7:0] LTW_ADDR_CAPT = 8'h30;
  // Control/status bit positions
  localparam int LTW_B_CAP_IE = 7;
  localparam int LTW_B_CAP_F = 6;
  localparam int LTW_B_DOUBLE = 5;
  localparam int LTW_B_TICK_IE = 4;
  localparam int LTW_B_TICK_F = 3;
  localparam int LTW_B_FORCE = 2;
  localparam int LTW_B_DOG_EN = 1;
  localparam int LTW_B_DELAY = 0;
  // Reset values
  localparam logic [7:0] LTW_COUNT_RST = 8'h00;
  localparam logic [7:0] LTW_CAPT_RST = 8'h00;
  // Timing
  localparam int LTW_OSC_DIV = 32;
  localparam logic [4:0] LTW_PRESC_TOP = 5'(LTW_OSC_DIV - 1);
  localparam logic [7:0] LTW_COUNT_TOP = 8'hF9;
  localparam int LTW_DOG_INTERVAL_OSC = 16000;
  localparam int LTW_RESUME_CLOCKS = 256;
  localparam logic [8:0] LTW_RESUME_LOAD = 9'(LTW_RESUME_CLOCKS);
  // AXI responses
  localparam logic [1:0] LTW_RESP_OKAY = 2'h0;
  localparam logic [1:0] LTW_RESP_DECERR = 2'h3;
endpackage

// ===== ltw_timer.sv
// Timebase counter, watchdog and input capture behind an AXI4-Lite slave.
// Assumes clk_in is the oscillator; core-side inputs share its domain,
// the capture pin and option strap come from outside and are synchronised.
//
// Behaviour
// - Counter starts at zero after reset, steps every 32 clocks, not software-visible.
// - Counter wraps after F9h to zero; that wrap is an overflow.
// - Tick every overflow, or every second overflow when period doubling is set.
// - Tick sets tick flag; interrupt request when tick interrupt enabled.
// - Reading control/status clears tick flag; writing it does nothing.
// - Enabled watchdog without pending refresh resets the device after its interval.
// - Software sets delay bit to postpone; hardware clears it each interval end.
// - Interval timed from reset; enabling after it elapsed resets at once.
// - With software enable bit set, writing one to force bit resets immediately.
// - Force bit set on watchdog reset; cleared by low-voltage reset or software after read.
// - Force bit set when watchdog becomes enabled gives immediate reset.
// - Hardware watchdog option keeps watchdog active, ignoring software enable.
// - Halt stops counter and watchdog; active watchdog resets on halt unless halt option set; resumes 257 clocks after wakeup.
// - Capture pin edge copies counter into capture register and sets flag.
// - Captures suppressed while flag set; capture register read clears it.
// - Counter runs in slow, wait, active-halt; stops only in halt.
// - Separate tick and capture requests, gated by enables and processor mask.
// - Enabled capture event wakes the device from halt.
// - Capture register read-only, resets to zero, holds last accepted capture.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ltw_timer
  import ltw_pkg::*;
#(
  parameter int DOG_CYCLES = ltw_pkg::LTW_DOG_INTERVAL_OSC
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic lvd_reset_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic capture_input_pin_in,
  input wire logic hw_dog_option_in,
  input wire logic halt_dog_option_in,
  input wire logic halt_in,
  input wire logic cpu_irq_mask_in,
  output logic tick_irq_out,
  output logic capture_irq_out,
  output logic halt_wake_out,
  output logic dog_reset_out
);
  import ltw_pkg::*;

  localparam logic [13:0] DOG_LAST = 14'(DOG_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [4:0] presc_q;
  logic [7:0] count_q;
  logic odd_q;
  logic [13:0] dog_cnt_q;
  logic [8:0] resume_q;
  logic halt_prev_q;
  logic expired_q;
  logic active_prev_q;
  logic dog_reset_q;
  logic cap_ie_q, cap_f_q, double_q, tick_ie_q, tick_f_q;
  logic force_q, dog_en_q, delay_q, read_seen_q;
  logic [7:0] capt_q;
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic opt_s1_q, opt_s2_q;
  logic tick_irq_q, cap_irq_q, wake_q;
  logic aw_full_q, w_full_q, aw_rdy_q, w_rdy_q, bvalid_q;
  logic [7:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic [1:0] bresp_q;
  logic ar_rdy_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI decode
  wire aw_take = s_axi_awvalid_in && aw_rdy_q;
  wire w_take = s_axi_wvalid_in && w_rdy_q;
  wire write_go = aw_full_q && w_full_q && !bvalid_q;
  wire wr_ctrl = write_go && wlane_q && (awaddr_q == LTW_ADDR_CTRL);
  wire wr_hit = (awaddr_q == LTW_ADDR_CTRL) || (awaddr_q == LTW_ADDR_CAPT);
  wire ar_take = s_axi_arvalid_in && ar_rdy_q;
  wire rd_ctrl = ar_take && (s_axi_araddr_in == LTW_ADDR_CTRL);
  wire rd_capt = ar_take && (s_axi_araddr_in == LTW_ADDR_CAPT);
  wire rd_hit = rd_ctrl || rd_capt;
  wire aw_full_d = (aw_full_q || aw_take) && !write_go;
  wire w_full_d = (w_full_q || w_take) && !write_go;
  wire bvalid_d = bvalid_q ? !s_axi_bready_in : write_go;
  wire [7:0] ctrl_view = {cap_ie_q, cap_f_q, double_q, tick_ie_q, tick_f_q,
                          force_q, dog_en_q, delay_q};

  ////////////////////////////////////////////////////////////////////////////
  // Timebase
  wire run = !halt_in;
  wire osc_en = run && (presc_q == LTW_PRESC_TOP);
  wire ovf = osc_en && (count_q == LTW_COUNT_TOP);
  wire tick = ovf && (!double_q || odd_q);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  wire dog_active = opt_s2_q || dog_en_q;
  // Release cycle itself is held too, so the frozen span is 257 clocks
  wire dog_run = run && !halt_prev_q && (resume_q == 9'h0_00);
  wire dog_end = dog_run && (dog_cnt_q == DOG_LAST);
  wire force_wr = wr_ctrl && wbyte_q[LTW_B_FORCE];
  wire fire_timeout = dog_active && dog_end && !delay_q;
  wire fire_late = dog_active && expired_q;
  wire fire_force = force_wr && dog_en_q;
  wire fire_stale = dog_active && !active_prev_q && force_q;
  wire fire_halt = halt_in && dog_active && !halt_dog_option_in;
  wire fire = fire_timeout || fire_late || fire_force || fire_stale || fire_halt;

  ////////////////////////////////////////////////////////////////////////////
  // Capture
  wire pin_edge = pin_s2_q ^ pin_s3_q;
  wire capture = pin_edge && !cap_f_q;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers; first stage feeds only the second
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      opt_s1_q <= 1'b0;
      opt_s2_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= capture_input_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      opt_s1_q <= hw_dog_option_in;
      opt_s2_q <= opt_s1_q;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      presc_q <= 5'h0_0;
      count_q <= LTW_COUNT_RST;
      odd_q <= 1'b0;
    end
    else if (run)
    begin
      presc_q <= presc_q + 5'h0_1;
      if (osc_en)
        count_q <= ovf ? LTW_COUNT_RST : count_q + 8'h0_1;
      if (ovf)
        odd_q <= !odd_q;
    end
  end

  // Watchdog interval counter, runs from reset regardless of enable
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      dog_cnt_q <= 14'h0_000;
      resume_q <= 9'h0_00;
      halt_prev_q <= 1'b0;
      expired_q <= 1'b0;
      active_prev_q <= 1'b0;
      dog_reset_q <= 1'b0;
    end
    else
    begin
      halt_prev_q <= halt_in;
      active_prev_q <= dog_active;
      if (halt_prev_q && !halt_in)
        resume_q <= LTW_RESUME_LOAD;
      else if (resume_q != 9'h0_00)
        resume_q <= resume_q - 9'h0_01;
      if (dog_run)
        dog_cnt_q <= dog_end ? 14'h0_000 : dog_cnt_q + 14'h0_001;
      if (dog_end && !dog_active)
        expired_q <= 1'b1;
      if (fire)
        dog_reset_q <= 1'b1; // Held until the system reset arrives
    end
  end

  // Force/status survives ordinary resets; only low-voltage reset or a write after a read clears it
  always_ff @(posedge clk_in or posedge lvd_reset_in)
  begin
    if (lvd_reset_in)
      force_q <= 1'b0;
    else if (fire || force_wr)
      force_q <= 1'b1;
    else if (wr_ctrl && read_seen_q)
      force_q <= 1'b0;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cap_ie_q <= 1'b0;
      double_q <= 1'b0;
      tick_ie_q <= 1'b0;
      dog_en_q <= 1'b0;
      delay_q <= 1'b0;
      read_seen_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        cap_ie_q <= wbyte_q[LTW_B_CAP_IE];
        double_q <= wbyte_q[LTW_B_DOUBLE];
        tick_ie_q <= wbyte_q[LTW_B_TICK_IE];
        dog_en_q <= wbyte_q[LTW_B_DOG_EN];
      end
      if (wr_ctrl && wbyte_q[LTW_B_DELAY])
        delay_q <= 1'b1;
      else if (dog_end)
        delay_q <= 1'b0;
      if (rd_ctrl)
        read_seen_q <= 1'b1;
      else if (wr_ctrl)
        read_seen_q <= 1'b0;
    end
  end

  // Event flags: a set in the clearing cycle wins
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tick_f_q <= 1'b0;
      cap_f_q <= 1'b0;
      capt_q <= LTW_CAPT_RST;
    end
    else
    begin
      if (tick)
        tick_f_q <= 1'b1;
      else if (rd_ctrl)
        tick_f_q <= 1'b0;
      if (capture)
      begin
        cap_f_q <= 1'b1;
        capt_q <= count_q;
      end
      else if (rd_capt)
        cap_f_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tick_irq_q <= 1'b0;
      cap_irq_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      tick_irq_q <= tick_f_q && tick_ie_q && !cpu_irq_mask_in;
      cap_irq_q <= cap_f_q && cap_ie_q && !cpu_irq_mask_in;
      wake_q <= cap_f_q && cap_ie_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_rdy_q <= 1'b0;
      w_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bresp_q <= LTW_RESP_OKAY;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      aw_rdy_q <= !aw_full_d && !bvalid_d;
      w_rdy_q <= !w_full_d && !bvalid_d;
      bvalid_q <= bvalid_d;
      if (aw_take)
        awaddr_q <= s_axi_awaddr_in;
      if (w_take)
      begin
        wbyte_q <= s_axi_wdata_in[7:0];
        wlane_q <= s_axi_wstrb_in[0];
      end
      if (write_go)
        bresp_q <= wr_hit ? LTW_RESP_OKAY : LTW_RESP_DECERR;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= LTW_RESP_OKAY;
    end
    else if (ar_take)
    begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_ctrl ? ctrl_view : (rd_capt ? capt_q : 8'h00)};
      rresp_q <= rd_hit ? LTW_RESP_OKAY : LTW_RESP_DECERR;
    end
    else if (rvalid_q && s_axi_rready_in)
    begin
      rvalid_q <= 1'b0;
      ar_rdy_q <= 1'b1;
    end
    else if (!rvalid_q)
      ar_rdy_q <= 1'b1;
  end

  assign s_axi_awready_out = aw_rdy_q;
  assign s_axi_wready_out = w_rdy_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = ar_rdy_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign tick_irq_out = tick_irq_q;
  assign capture_irq_out = cap_irq_q;
  assign halt_wake_out = wake_q;
  assign dog_reset_out = dog_reset_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_ovf_wrap;
    ovf ##1 (count_q == LTW_COUNT_RST);
  endsequence

  AST_WRAP_AT_TOP: assert property (
    ovf |-> s_ovf_wrap)
    else $error("counter did not wrap after top value");

  AST_STEP_EVERY_32: assert property (
    (osc_en && !ovf) |=> (count_q == $past(count_q) + 8'h01) ##1 (count_q == $past(count_q)))
    else $error("counter stepped off the divided rate");

  AST_DOUBLE_SKIP: assert property (
    (ovf && double_q && !odd_q) |-> !tick)
    else $error("tick on skipped overflow");

  AST_TICK_SETS_FLAG: assert property (
    tick |=> tick_f_q ##1 (tick_irq_q == ($past(tick_ie_q) && !$past(cpu_irq_mask_in))))
    else $error("tick flag or request wrong");

  AST_READ_CLEARS_TICK: assert property (
    (rd_ctrl && !tick) |=> !tick_f_q)
    else $error("tick flag survived read");

  AST_TIMEOUT_RESETS: assert property (
    (dog_active && dog_end && !delay_q) |=> dog_reset_out)
    else $error("watchdog timeout missed");

  AST_DELAY_CLEARED: assert property (
    (dog_end && !(wr_ctrl && wbyte_q[LTW_B_DELAY])) |=> !delay_q)
    else $error("delay bit not cleared at interval end");

  AST_FORCE_RESETS: assert property (
    (force_wr && dog_en_q) |=> dog_reset_out && force_q)
    else $error("forced reset missed");

  AST_CAPTURE_HELD: assert property (
    (cap_f_q && !rd_capt) |=> cap_f_q && $stable(capt_q))
    else $error("capture changed while flag set");

  AST_CAPTURE_TAKEN: assert property (
    capture |=> cap_f_q && (capt_q == $past(count_q)))
    else $error("capture value wrong");

  AST_HALT_FREEZES: assert property (
    halt_in |=> $stable(count_q))
    else $error("counter moved in halt");

  AST_RESUME_DELAY: assert property (
    (halt_prev_q && !halt_in) |=> !dog_run [*8])
    else $error("watchdog resumed early");

endmodule
`default_nettype wire

// ===== ltw_edge_src.sv
// Far-side model: drives the capture pin with single edges on request.
// Assumes one toggle pulse per edge, sampled on clk_in.
`timescale 1ns/1ns
`default_nettype none
module ltw_edge_src
(
  input wire logic clk_in,
  input wire logic toggle_in,
  input wire logic [7:0] delay_in,
  output logic pin_out
);
  logic [7:0] cnt_q = 8'h00;
  logic busy_q = 1'b0;
  // Pin is never reset, as an external line would not be
  logic pin_q = 1'b0;
  assign pin_out = pin_q;
  // Delay lets the edge come promptly or late
  always @(posedge clk_in)
  begin
    if (toggle_in)
    begin
      busy_q <= 1'b1;
      cnt_q <= delay_in;
    end
    else if (busy_q && cnt_q == 8'h00)
    begin
      busy_q <= 1'b0;
      pin_q <= ~pin_q;
    end
    else if (busy_q)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the timebase, watchdog and capture block.
// Assumes the package constants; watchdog interval shortened to 400.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ltw_pkg::*;
  localparam int DOG = 400;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic lvd_reset_in = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic hw_dog = 1'b0;
  logic halt_opt = 1'b0;
  logic halt = 1'b0;
  logic mask = 1'b0;
  logic toggle = 1'b0;
  logic [7:0] delay = 8'h00;
  logic awready, wready, bvalid, arready, rvalid;
  logic pin, tick_irq, cap_irq, wake, dog_rst;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] cap_exp;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 clk_in = ~clk_in;
  always @(posedge clk_in)
    cyc <= reset_in ? 0 : cyc + 1;

  ltw_timer #(.DOG_CYCLES(DOG)) dut
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .lvd_reset_in(lvd_reset_in),
    .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr),
    .s_axi_awprot_in(3'h0),
    .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready),
    .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF),
    .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr),
    .s_axi_arprot_in(3'h0),
    .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp),
    .capture_input_pin_in(pin),
    .hw_dog_option_in(hw_dog),
    .halt_dog_option_in(halt_opt),
    .halt_in(halt),
    .cpu_irq_mask_in(mask),
    .tick_irq_out(tick_irq),
    .capture_irq_out(cap_irq),
    .halt_wake_out(wake),
    .dog_reset_out(dog_rst)
  );
  ltw_edge_src src
  (
    .clk_in(clk_in),
    .toggle_in(toggle),
    .delay_in(delay),
    .pin_out(pin)
  );

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk(32'(got), 32'(exp));
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = LTW_RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                      input logic [1:0] er = LTW_RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    chk(32'(rresp), 32'(er));
    chk(rdata, {24'h00_0000, e});
  endtask

  task automatic do_reset(input logic low_voltage_detect);
    @(posedge clk_in);
    reset_in <= 1'b1;
    lvd_reset_in <= low_voltage_detect;
    idle(2);
    reset_in <= 1'b0;
    lvd_reset_in <= 1'b0;
  endtask

  task automatic edge_req(input logic [7:0] d);
    @(posedge clk_in);
    toggle <= 1'b1;
    delay <= d;
    @(posedge clk_in);
    toggle <= 1'b0;
  endtask

  task automatic wait_dog(input int mx);
    int n;
    n = 0;
    while (dog_rst !== 1'b1 && n < mx)
    begin
      @(posedge clk_in);
      n++;
    end
    chkb(dog_rst, 1'b1);
  endtask

  task automatic wait_tick;
    int n;
    n = 0;
    while (tick_irq !== 1'b1 && n < 20000)
    begin
      @(posedge clk_in);
      n++;
    end
  endtask

  // Gap between two ticks, clearing the flag in between
  task automatic tick_gap(input int exp, input logic [7:0] en);
    time t0;
    wait_tick();
    t0 = $time;
    rchk(LTW_ADDR_CTRL, en | 8'h08);
    idle(2);
    wait_tick();
    chk(32'(($time - t0) / 8), 32'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    stop_test();
  end

  initial
  begin
    idle(2);
    reset_in <= 1'b0;
    lvd_reset_in <= 1'b0;
    rchk(LTW_ADDR_CTRL, 8'h00);
    rchk(LTW_ADDR_CAPT, 8'h00);
    rchk(8'h40, 8'h00, LTW_RESP_DECERR);
    wr(8'h44, 8'hFF, LTW_RESP_DECERR);
    wr(LTW_ADDR_CTRL, 8'h80);
    while (cyc % 32 != 8)
      @(posedge clk_in);
    cap_exp = 8'((cyc / 32) % 250);
    edge_req(8'h00);
    idle(8);
    chkb(cap_irq, 1'b1);
    chkb(wake, 1'b1);
    mask <= 1'b1;
    idle(3);
    chkb(cap_irq, 1'b0);
    chkb(wake, 1'b1);
    mask <= 1'b0;
    rchk(LTW_ADDR_CTRL, 8'hC0);
    wr(LTW_ADDR_CTRL, 8'h80);
    rchk(LTW_ADDR_CTRL, 8'hC0);
    edge_req(8'h14);
    idle(40);
    rchk(LTW_ADDR_CAPT, cap_exp);
    rchk(LTW_ADDR_CTRL, 8'h80);
    wr(LTW_ADDR_CTRL, 8'h10);
    tick_gap(8000, 8'h10);
    mask <= 1'b1;
    idle(3);
    chkb(tick_irq, 1'b0);
    mask <= 1'b0;
    idle(3);
    chkb(tick_irq, 1'b1);
    rchk(LTW_ADDR_CTRL, 8'h18);
    wr(LTW_ADDR_CTRL, 8'h18);
    rchk(LTW_ADDR_CTRL, 8'h10);
    wr(LTW_ADDR_CTRL, 8'h30);
    tick_gap(16000, 8'h30);
    // Watchdog kept alive, then left to expire
    do_reset(1'b0);
    repeat (6)
    begin
      wr(LTW_ADDR_CTRL, 8'h03);
      idle(150);
    end
    chkb(dog_rst, 1'b0);
    wait_dog(900);
    do_reset(1'b0);
    rchk(LTW_ADDR_CTRL, 8'h04);
    wr(LTW_ADDR_CTRL, 8'h06);
    wait_dog(20);
    do_reset(1'b0);
    rchk(LTW_ADDR_CTRL, 8'h04);
    wr(LTW_ADDR_CTRL, 8'h00);
    rchk(LTW_ADDR_CTRL, 8'h00);
    wr(LTW_ADDR_CTRL, 8'h03);
    wr(LTW_ADDR_CTRL, 8'h07);
    wait_dog(20);
    do_reset(1'b1);
    idle(DOG + 50);
    chkb(dog_rst, 1'b0);
    wr(LTW_ADDR_CTRL, 8'h02);
    wait_dog(20);
    do_reset(1'b1);
    hw_dog <= 1'b1;
    idle(300);
    chkb(dog_rst, 1'b0);
    wait_dog(200);
    hw_dog <= 1'b0;
    do_reset(1'b1);
    halt_opt <= 1'b1;
    wr(LTW_ADDR_CTRL, 8'h03);
    halt <= 1'b1;
    idle(1000);
    chkb(dog_rst, 1'b0);
    halt <= 1'b0;
    idle(250);
    chkb(dog_rst, 1'b0);
    wait_dog(1200);
    do_reset(1'b1);
    halt_opt <= 1'b0;
    wr(LTW_ADDR_CTRL, 8'h03);
    halt <= 1'b1;
    wait_dog(20);
    halt <= 1'b0;
    stop_test();
  end
endmodule
`default_nettype wire
